// file: inc/mps_pkg.sv
// Constants shared by the multiprobe statistics sync block
package mps_pkg;

    // Clock rate in MHz
    localparam int MPS_CLK_MHZ = 250;
    // LED flash half period in ms
    localparam int MPS_FLASH_HALF_MS = 250;
    // Cycles per flash half period, rounded down
    localparam int MPS_FLASH_CYC = MPS_FLASH_HALF_MS * 1000 * MPS_CLK_MHZ;
    localparam int MPS_FLASH_W = 26;

    // Register offsets
    localparam logic [3:0] MPS_REG_CTRL = 4'h0;
    localparam logic [3:0] MPS_REG_STAT = 4'h4;
    localparam logic [3:0] MPS_REG_TRIG = 4'h8;
    localparam logic [3:0] MPS_REG_SNAPCNT = 4'hC;

    // Control field positions
    localparam int MPS_CTRL_MASTER = 0;
    localparam int MPS_CTRL_COLLECT = 1;
    localparam int MPS_CTRL_SNAP = 2;
    localparam int MPS_CTRL_SE_OUT = 3;
    localparam int MPS_CTRL_DF_OUT = 4;
    localparam int MPS_CTRL_SE_VAL = 5;
    localparam int MPS_CTRL_DF_VAL = 6;
    localparam logic [31:0] MPS_CTRL_RESET = 32'h0000_0000;

    // Collection states for master and slave, Gray coded
    typedef enum logic [1:0] {
        MPS_IDLE = 2'b00,
        MPS_RUN = 2'b01,
        MPS_SNAP = 2'b11
    } mps_state_t;

endpackage

// file: rtl/mps_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ns
module mps_sync2 (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic din,
    output logic dout
);
    // First stage, read only by the second
    logic meta_q;

    // Shift the level through two stages
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// file: rtl/mps_stats_sync.sv
// Multiprobe statistics sync: role, enable, snapshot, LED and triggers
`timescale 1ns/1ns
module mps_stats_sync
    import mps_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic link_en_in,
    output logic link_en_out,
    output logic link_en_oe,
    input wire logic link_snap_in,
    output logic link_snap_out,
    output logic link_snap_oe,
    output logic link_role_master,
    input wire logic link_peer_master,
    input wire logic trig_se_in,
    output logic trig_se_out,
    output logic trig_se_oe,
    input wire logic trig_dp_in,
    input wire logic trig_dn_in,
    output logic trig_dp_out,
    output logic trig_dn_out,
    output logic trig_df_oe,
    output logic role_led,
    output logic collect_active,
    output logic snap_pulse
);
    // Control register and its next value
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    // Snapshot counter
    logic [15:0] snapcnt_q;
    // Flash divider and phase
    logic [MPS_FLASH_W-1:0] flash_cnt_q;
    logic flash_q;
    // Collection state, both roles
    mps_state_t state_q;
    mps_state_t state_d;
    // Synchronised link lines
    logic en_s;
    logic snap_s;
    logic peer_s;
    logic tse_s;
    logic tdf_s;
    logic snap_s_q;
    // Trigger edge sticky flags
    logic tse_seen_q;
    logic tdf_seen_q;
    logic tse_s_q;
    logic tdf_s_q;

    // Named control fields
    wire is_master = ctrl_q[MPS_CTRL_MASTER];
    wire m_collect = ctrl_q[MPS_CTRL_COLLECT];
    wire m_snap = ctrl_q[MPS_CTRL_SNAP];
    wire wr_ctrl = reg_wr && (reg_addr == MPS_REG_CTRL);
    wire wr_trig = reg_wr && (reg_addr == MPS_REG_TRIG);
    wire diff_rx = trig_dp_in & ~trig_dn_in;
    wire tse_rise = tse_s & ~tse_s_q;
    wire tdf_rise = tdf_s & ~tdf_s_q;
    // Enable seen by this unit: own command as master, link as slave
    wire collect_now = is_master ? m_collect : en_s;
    wire snap_rise = is_master ? 1'b0 : (snap_s & ~snap_s_q);
    wire flash_wrap = (flash_cnt_q == MPS_FLASH_W'(MPS_FLASH_CYC - 1));

    // Synchronisers for every incoming link line
    mps_sync2 u_sync_en (.ref_clk(ref_clk), .nrst(nrst),
        .din(link_en_in), .dout(en_s));
    mps_sync2 u_sync_snap (.ref_clk(ref_clk), .nrst(nrst),
        .din(link_snap_in), .dout(snap_s));
    mps_sync2 u_sync_peer (.ref_clk(ref_clk), .nrst(nrst),
        .din(link_peer_master), .dout(peer_s));
    mps_sync2 u_sync_tse (.ref_clk(ref_clk), .nrst(nrst),
        .din(trig_se_in), .dout(tse_s));
    mps_sync2 u_sync_tdf (.ref_clk(ref_clk), .nrst(nrst),
        .din(diff_rx), .dout(tdf_s));

    // Control write; snapshot bit is self clearing
    always_comb begin
        ctrl_d = ctrl_q;
        ctrl_d[MPS_CTRL_SNAP] = 1'b0;
        if (wr_ctrl) begin
            ctrl_d = reg_wdata;
        end
    end

    // Collection state machine for master and slave
    always_comb begin
        state_d = state_q;
        case (state_q)
            MPS_IDLE: begin
                if (collect_now) begin
                    state_d = MPS_RUN;
                end
            end
            MPS_RUN: begin
                if (!collect_now) begin
                    state_d = MPS_IDLE;
                end else if (snap_rise || (is_master && m_snap)) begin
                    state_d = MPS_SNAP;
                end
            end
            MPS_SNAP: begin
                state_d = collect_now ? MPS_RUN : MPS_IDLE;
            end
            default: begin
                state_d = MPS_IDLE;
            end
        endcase
    end

    // Register control, state and the delayed snapshot line
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= MPS_CTRL_RESET;
            state_q <= MPS_IDLE;
            snap_s_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            state_q <= state_d;
            snap_s_q <= snap_s;
        end
    end

    // Snapshot counter counts captures
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            snapcnt_q <= 16'h0000;
            snap_pulse <= 1'b0;
        end else begin
            snap_pulse <= (state_d == MPS_SNAP);
            if (state_d == MPS_SNAP) begin
                snapcnt_q <= snapcnt_q + 16'h0001;
            end
        end
    end

    // Enable and snapshot lines are driven only by the master
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            link_en_out <= 1'b0;
            link_en_oe <= 1'b0;
            link_snap_out <= 1'b0;
            link_snap_oe <= 1'b0;
            link_role_master <= 1'b0;
            collect_active <= 1'b0;
        end else begin
            link_en_out <= is_master && m_collect;
            link_en_oe <= is_master;
            link_snap_out <= is_master && m_snap;
            link_snap_oe <= is_master;
            link_role_master <= is_master;
            collect_active <= collect_now;
        end
    end

    // Flash divider for the master LED
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flash_cnt_q <= '0;
            flash_q <= 1'b0;
        end else if (flash_wrap) begin
            flash_cnt_q <= '0;
            flash_q <= ~flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 1'b1;
        end
    end

    // Role LED: flash as master, collection state as slave
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            role_led <= 1'b0;
        end else if (is_master) begin
            role_led <= flash_q;
        end else begin
            role_led <= collect_now;
        end
    end

    // Trigger ports, each with its own direction and value
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            trig_se_out <= 1'b0;
            trig_se_oe <= 1'b0;
            trig_dp_out <= 1'b0;
            trig_dn_out <= 1'b1;
            trig_df_oe <= 1'b0;
            tse_s_q <= 1'b0;
            tdf_s_q <= 1'b0;
            tse_seen_q <= 1'b0;
            tdf_seen_q <= 1'b0;
        end else begin
            trig_se_oe <= ctrl_q[MPS_CTRL_SE_OUT];
            trig_se_out <= ctrl_q[MPS_CTRL_SE_VAL];
            trig_df_oe <= ctrl_q[MPS_CTRL_DF_OUT];
            trig_dp_out <= ctrl_q[MPS_CTRL_DF_VAL];
            trig_dn_out <= ~ctrl_q[MPS_CTRL_DF_VAL];
            tse_s_q <= tse_s;
            tdf_s_q <= tdf_s;
            // Rising edge sets, write one clears; set wins
            tse_seen_q <= tse_rise |
                (tse_seen_q & ~(wr_trig & reg_wdata[0]));
            tdf_seen_q <= tdf_rise |
                (tdf_seen_q & ~(wr_trig & reg_wdata[1]));
        end
    end

    // Read data, valid the cycle after the read strobe
    wire [31:0] stat_word = {26'h000_0000, peer_s, tdf_s, tse_s,
        state_q, collect_now};
    wire [31:0] rd_mux =
        (reg_addr == MPS_REG_CTRL) ? ctrl_q :
        (reg_addr == MPS_REG_STAT) ? stat_word :
        (reg_addr == MPS_REG_TRIG) ? {30'h0000_0000, tdf_seen_q,
            tse_seen_q} :
        (reg_addr == MPS_REG_SNAPCNT) ? {16'h0000, snapcnt_q} :
        32'h0000_0000;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

// file: tb/mps_stats_sync_assertions.sv
// Port checks for the statistics sync block
`timescale 1ns/1ns
module mps_stats_sync_assertions (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic link_en_in,
    input wire logic link_en_oe,
    input wire logic link_snap_oe,
    input wire logic link_role_master,
    input wire logic trig_dp_out,
    input wire logic trig_dn_out,
    input wire logic role_led,
    input wire logic collect_active,
    input wire logic snap_pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Enable line edges seen while a slave
    sequence s_up; !link_role_master ##0 $rose(link_en_in); endsequence
    sequence s_dn; !link_role_master ##0 $fell(link_en_in); endsequence
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
    endproperty
    property p_en_up; s_up |-> ##[2:3] collect_active; endproperty
    property p_en_dn; s_dn |-> ##[2:3] !collect_active; endproperty
    property p_led; $stable(link_role_master) && !link_role_master
        |-> role_led == collect_active; endproperty
    property p_en_oe; link_en_oe |-> link_role_master; endproperty
    property p_sn_oe; link_snap_oe |-> link_role_master; endproperty
    property p_diff; trig_dn_out != trig_dp_out; endproperty
    property p_gap; snap_pulse |=> !snap_pulse[*2]; endproperty
    property p_cap; snap_pulse |-> collect_active; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
    a_en_up: assert property (p_en_up) else $error("no start");
    a_en_dn: assert property (p_en_dn) else $error("no stop");
    a_led: assert property (p_led) else $error("slave led");
    a_en_oe: assert property (p_en_oe) else $error("en drive");
    a_sn_oe: assert property (p_sn_oe) else $error("snap drive");
    a_diff: assert property (p_diff) else $error("diff pair");
    a_gap: assert property (p_gap) else $error("snap width");
    a_cap: assert property (p_cap) else $error("snap idle");
endmodule

// file: tb/mps_peer.sv
// Model of another unit on the link
`timescale 1ns/1ns
module mps_peer (
    input wire logic ref_clk,
    input wire logic go_master,
    input wire logic go_collect,
    input wire logic go_snap,
    output logic en_oe,
    output logic en_out,
    output logic snap_out,
    output logic is_master
);
    // Lines follow the commands one edge later
    always_ff @(posedge ref_clk) begin
        is_master <= go_master;
        en_oe <= go_master;
        en_out <= go_master & go_collect;
        snap_out <= go_master & go_snap;
    end
endmodule

// file: tb/multiprobe_stats_sync_tb.sv
// Self-checking bench for the statistics sync block
`timescale 1ns/1ns
module multiprobe_stats_sync_tb;
    logic ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
    logic [3:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0;
    logic [31:0] exp_q[$];
    logic [15:0] rnd = 16'h1550;
    logic go_m = 0, go_c = 0, go_s = 0, se_in = 0, dp_in = 0, dn_in = 1;
    logic p_oe, p_en, p_sn, p_is, link_en_out, link_en_oe, link_snap_out;
    logic link_snap_oe, link_role_master, trig_se_out, trig_se_oe;
    logic trig_dp_out, trig_dn_out, trig_df_oe, role_led, collect_active;
    logic snap_pulse;
    logic [31:0] reg_rdata;
    int err_total = 0, n_compared = 0, n_snap = 0, cyc_n = 0, n_lsn = 0;
    // Released link lines settle low
    wire en_w = link_en_oe ? link_en_out : p_oe ? p_en : 1'b0;
    wire sn_w = link_snap_oe ? link_snap_out : p_oe ? p_sn : 1'b0;
    always #2 ref_clk = ~ref_clk;
    mps_peer u_peer (.ref_clk, .go_master(go_m), .go_collect(go_c),
        .go_snap(go_s), .en_oe(p_oe), .en_out(p_en), .snap_out(p_sn),
        .is_master(p_is));
    mps_stats_sync dut (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .link_en_in(en_w), .link_en_out, .link_en_oe,
        .link_snap_in(sn_w), .link_snap_out, .link_snap_oe,
        .link_role_master, .link_peer_master(p_is), .trig_se_in(se_in),
        .trig_se_out, .trig_se_oe, .trig_dp_in(dp_in), .trig_dn_in(dn_in),
        .trig_dp_out, .trig_dn_out, .trig_df_oe, .role_led, .collect_active,
        .snap_pulse);
    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(logic [31:0] v, logic [31:0] e);
        n_compared++;
        if (v !== e) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, v, e);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One-cycle register write and read
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 0;
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Read answers, snapshot pulses and the hang limit
    always @(posedge ref_clk) begin
        // Read data stand only in the cycle after the strobe
        if (rd_d) chk(reg_rdata, exp_q.pop_front());
        rd_d = reg_rd;
        if (snap_pulse) n_snap++;
        // Snapshot pulses put on the link as master
        if (link_snap_out) n_lsn++;
        cyc_n++;
        if (cyc_n == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1;
        rd(4'h0, 32'h0000_0000);
        rnd = lfsr(rnd);
        wr(4'h2, {rnd, rnd});
        rd(4'h2, 32'h0000_0000);
        rd(4'h0, 32'h0000_0000);
        // Slave under a peer master
        @(posedge ref_clk);
        go_m <= 1;
        go_c <= 1;
        settle(6);
        chk(role_led, 1);
        rd(4'h4, 32'h0000_0023);
        @(posedge ref_clk);
        go_s <= 1;
        @(posedge ref_clk);
        go_s <= 0;
        settle(8);
        chk(n_snap, 1);
        rd(4'hC, 32'h0000_0001);
        @(posedge ref_clk);
        go_c <= 0;
        settle(6);
        chk(role_led, 0);
        chk(collect_active, 0);
        // This unit takes over as master
        @(posedge ref_clk);
        go_m <= 0;
        wr(4'h0, 32'h0000_0003);
        settle(3);
        chk({link_role_master, link_en_oe, link_en_out}, 7);
        chk(link_snap_oe, 1);
        // Flash phase is still low this early in the run
        chk(role_led, 0);
        wr(4'h0, 32'h0000_0007);
        settle(8);
        chk(n_snap, 2);
        chk(n_lsn, 1);
        rd(4'hC, 32'h0000_0002);
        wr(4'h0, 32'h0000_007B);
        settle(3);
        chk({trig_df_oe, trig_se_oe, trig_se_out, trig_dp_out,
            trig_dn_out}, 30);
        wr(4'h0, 32'h0000_0003);
        @(posedge ref_clk);
        se_in <= 1;
        dp_in <= 1;
        dn_in <= 0;
        settle(6);
        rd(4'h8, 32'h0000_0003);
        wr(4'h8, 32'h0000_0003);
        rd(4'h8, 32'h0000_0000);
        settle(3);
        give_verdict();
    end
endmodule
bind mps_stats_sync mps_stats_sync_assertions u_chk (.ref_clk, .nrst,
    .reg_rd, .reg_rdata, .link_en_in, .link_en_oe, .link_snap_oe,
    .link_role_master, .trig_dp_out, .trig_dn_out, .role_led,
    .collect_active, .snap_pulse);
